// ---- core/fsf_map.vh ----
// Constants for the fault status flag block: offsets, bit positions, resets.
// Assumes inclusion by bare name from the core/ design files.
`ifndef FSF_MAP_VH
`define FSF_MAP_VH

// Widths
`define FSF_ADDR_W        8
`define FSF_DATA_W        32
`define FSF_PRIO_W        8
`define FSF_NFLAGS        5

// Register offsets (byte addresses)
`define FSF_STATUS_OFS    8'h00
`define FSF_BUS_ADDR_OFS  8'h04
`define FSF_MEM_ADDR_OFS  8'h08

// Status word bit positions
`define FSF_BIT_IMPRECISE 10
`define FSF_BIT_PRECISE   9
`define FSF_BIT_FETCH     8
`define FSF_BIT_MEMVALID  7
`define FSF_BIT_RSVD_HI   6
`define FSF_BIT_RSVD_LO   5
`define FSF_BIT_STACKING  4

// Flag vector indices
`define FSF_IDX_STACKING  0
`define FSF_IDX_MEMVALID  1
`define FSF_IDX_FETCH     2
`define FSF_IDX_PRECISE   3
`define FSF_IDX_IMPRECISE 4

// Reset values
`define FSF_STATUS_RST    32'h00000000
`define FSF_ADDR_RST      32'h00000000
`define FSF_RSVD_VAL      2'h0

// Timing: read data follows the read strobe by this many cycles
`define FSF_RD_LAT        1

`endif

// ---- core/fsf_sticky_bit.v ----
// One sticky fault flag: set by a one-cycle event, cleared by a one written.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module fsf_sticky_bit (
  // Clock and reset
  input  wire clk_i,
  input  wire srst_i,
  // Control
  input  wire set_i,
  input  wire clr_i,
  // State
  output wire flag_o
);

  reg flag_reg;
  reg flag_next;

  always @* begin
    flag_next = flag_reg;
    if (clr_i) begin
      flag_next = 1'b0;
    end
    if (set_i) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule // fsf_sticky_bit

`default_nettype wire

// ---- core/fsf_addr_hold.v ----
// Fault address holding register, loaded on a one-cycle strobe.
// Assumes strobe and address come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsf_map.vh"

module fsf_addr_hold (
  // Clock and reset
  input  wire                    clk_i,
  input  wire                    srst_i,
  // Load
  input  wire                    load_i,
  input  wire [`FSF_DATA_W-1:0]  addr_i,
  // Held value
  output wire [`FSF_DATA_W-1:0]  addr_o
);

  reg [`FSF_DATA_W-1:0] addr_reg;

  always @(posedge clk_i) begin
    if (srst_i) begin
      addr_reg <= `FSF_ADDR_RST;
    end else if (load_i) begin
      addr_reg <= addr_i;
    end
  end

  assign addr_o = addr_reg;

endmodule // fsf_addr_hold

`default_nettype wire

// ---- core/fsf_status.v ----
// Fault status flags (bits 10..4) with bus and memory fault address capture.
// Assumes fault events are one-cycle pulses from core logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "fsf_map.vh"

module fsf_status (
  // Clock and reset
  input  wire                    clk_i,
  input  wire                    srst_i,
  // Register port
  input  wire [`FSF_ADDR_W-1:0]  addr_i,
  input  wire [`FSF_DATA_W-1:0]  wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  input  wire                    priv_i,
  output wire [`FSF_DATA_W-1:0]  rdata_o,
  // Data bus fault events
  input  wire                    precise_err_evt_i,
  input  wire                    imprecise_err_evt_i,
  input  wire [`FSF_DATA_W-1:0]  data_fault_addr_i,
  // Instruction fetch events
  input  wire                    prefetch_err_evt_i,
  input  wire                    issue_i,
  input  wire                    fetch_flush_i,
  // Memory management events
  input  wire                    mem_data_viol_evt_i,
  input  wire                    stacking_viol_evt_i,
  input  wire [`FSF_DATA_W-1:0]  mem_fault_addr_i,
  // Priority context
  input  wire [`FSF_PRIO_W-1:0]  cur_prio_i,
  input  wire [`FSF_PRIO_W-1:0]  bus_fault_prio_i,
  // Fault activation to the core
  output wire                    imprecise_pending_o,
  output wire                    imprecise_activate_o,
  output wire                    fetch_fault_activate_o,
  output wire                    stack_adjust_o,
  // Flag and address views
  output wire [`FSF_NFLAGS-1:0]  flags_o,
  output wire                    mem_fault_addr_valid_o,
  output wire [`FSF_DATA_W-1:0]  bus_fault_address_o,
  output wire [`FSF_DATA_W-1:0]  mem_fault_address_o
);

  // Imprecise fault sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PEND = 3'b010;
  localparam [2:0] ST_FIRE = 3'b100;

  // Bit position of each flag in the status word
  function integer fsf_pos;
    input integer idx;
    begin
      case (idx)
        `FSF_IDX_STACKING:  fsf_pos = `FSF_BIT_STACKING;
        `FSF_IDX_MEMVALID:  fsf_pos = `FSF_BIT_MEMVALID;
        `FSF_IDX_FETCH:     fsf_pos = `FSF_BIT_FETCH;
        `FSF_IDX_PRECISE:   fsf_pos = `FSF_BIT_PRECISE;
        default:            fsf_pos = `FSF_BIT_IMPRECISE;
      endcase
    end
  endfunction

  // Register decode
  wire                   sel_status;
  wire                   sel_bus_addr;
  wire                   sel_mem_addr;
  wire                   status_wr;
  wire                   rd_ok;

  // Flag control
  wire [`FSF_NFLAGS-1:0] flag_set;
  wire [`FSF_NFLAGS-1:0] flag_clr;
  wire [`FSF_NFLAGS-1:0] flag_q;
  wire [`FSF_DATA_W-1:0] status_word;

  // Address capture
  wire                   bus_addr_load;
  wire                   mem_addr_load;
  wire [`FSF_DATA_W-1:0] bus_addr_q;
  wire [`FSF_DATA_W-1:0] mem_addr_q;

  // Prefetch tracking
  reg                    fetch_held_reg;
  reg                    fetch_held_next;
  wire                   fetch_issue_fault;

  // Imprecise sequencer
  reg  [2:0]             imp_state_reg;
  reg  [2:0]             imp_state_next;
  wire                   higher_ctx;

  // Read data
  reg  [`FSF_DATA_W-1:0] rdata_reg;
  reg  [`FSF_DATA_W-1:0] rdata_next;

  // Stack pointer adjust pulse
  reg                    stack_adjust_reg;

  // Register decode; unprivileged accesses are ignored
  assign sel_status   = (addr_i == `FSF_STATUS_OFS);
  assign sel_bus_addr = (addr_i == `FSF_BUS_ADDR_OFS);
  assign sel_mem_addr = (addr_i == `FSF_MEM_ADDR_OFS);
  assign status_wr    = wr_i & priv_i & sel_status;
  assign rd_ok        = rd_i & priv_i;

  // Prefetch error waits for the issue of the faulting instruction
  always @* begin
    fetch_held_next = fetch_held_reg;
    if (fetch_issue_fault || fetch_flush_i) begin
      fetch_held_next = 1'b0;
    end
    if (prefetch_err_evt_i) begin
      fetch_held_next = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      fetch_held_reg <= 1'b0;
    end else begin
      fetch_held_reg <= fetch_held_next;
    end
  end

  assign fetch_issue_fault = fetch_held_reg & issue_i;

  // Set events per flag
  assign flag_set[`FSF_IDX_STACKING]  = stacking_viol_evt_i;
  assign flag_set[`FSF_IDX_MEMVALID]  = mem_addr_load;
  assign flag_set[`FSF_IDX_FETCH]     = fetch_issue_fault;
  assign flag_set[`FSF_IDX_PRECISE]   = precise_err_evt_i;
  assign flag_set[`FSF_IDX_IMPRECISE] = imprecise_err_evt_i;

  // One sticky cell per flag, cleared by a one at its own bit position
  genvar gi;
  generate
    for (gi = 0; gi < `FSF_NFLAGS; gi = gi + 1) begin : g_flag
      assign flag_clr[gi] = status_wr & wdata_i[fsf_pos(gi)];

      fsf_sticky_bit u_flag (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .set_i  (flag_set[gi]),
        .clr_i  (flag_clr[gi]),
        .flag_o (flag_q[gi])
      );
    end
  endgenerate

  // Flags are independent cells, so an imprecise flag survives a later precise one
  assign flags_o = flag_q;

  // Status word; reserved and unused bits read zero
  assign status_word = {
    {(`FSF_DATA_W-`FSF_BIT_IMPRECISE-1){1'b0}},
    flag_q[`FSF_IDX_IMPRECISE],
    flag_q[`FSF_IDX_PRECISE],
    flag_q[`FSF_IDX_FETCH],
    flag_q[`FSF_IDX_MEMVALID],
    `FSF_RSVD_VAL,
    flag_q[`FSF_IDX_STACKING],
    {`FSF_BIT_STACKING{1'b0}}
  };

  // Only a precise data error loads the bus fault address
  assign bus_addr_load = precise_err_evt_i;

  fsf_addr_hold u_bus_addr (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .load_i (bus_addr_load),
    .addr_i (data_fault_addr_i),
    .addr_o (bus_addr_q)
  );

  // Only a data access violation loads the memory fault address
  assign mem_addr_load = mem_data_viol_evt_i & ~stacking_viol_evt_i;

  fsf_addr_hold u_mem_addr (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .load_i (mem_addr_load),
    .addr_i (mem_fault_addr_i),
    .addr_o (mem_addr_q)
  );

  // Lower number is higher priority
  assign higher_ctx = (cur_prio_i < bus_fault_prio_i);

  // Imprecise fault held until the higher-priority contexts have returned
  always @* begin
    imp_state_next = imp_state_reg;
    case (imp_state_reg)
      ST_IDLE: begin
        if (imprecise_err_evt_i) begin
          if (higher_ctx) begin
            imp_state_next = ST_PEND;
          end else begin
            imp_state_next = ST_FIRE;
          end
        end
      end
      ST_PEND: begin
        if (!higher_ctx) begin
          imp_state_next = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (imprecise_err_evt_i && higher_ctx) begin
          imp_state_next = ST_PEND;
        end else if (imprecise_err_evt_i) begin
          imp_state_next = ST_FIRE;
        end else begin
          imp_state_next = ST_IDLE;
        end
      end
      default: begin
        imp_state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      imp_state_reg <= ST_IDLE;
    end else begin
      imp_state_reg <= imp_state_next;
    end
  end

  assign imprecise_pending_o  = (imp_state_reg == ST_PEND);
  assign imprecise_activate_o = (imp_state_reg == ST_FIRE);
  assign fetch_fault_activate_o = fetch_issue_fault;

  // Stacking violation does not stop the stack pointer update
  always @(posedge clk_i) begin
    if (srst_i) begin
      stack_adjust_reg <= 1'b0;
    end else begin
      stack_adjust_reg <= stacking_viol_evt_i;
    end
  end

  assign stack_adjust_o = stack_adjust_reg;

  // Read mux; unmapped or unprivileged reads give zero
  always @* begin
    rdata_next = {`FSF_DATA_W{1'b0}};
    if (rd_ok) begin
      if (sel_status) begin
        rdata_next = status_word;
      end else if (sel_bus_addr) begin
        rdata_next = bus_addr_q;
      end else if (sel_mem_addr) begin
        rdata_next = mem_addr_q;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= `FSF_STATUS_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o                = rdata_reg;
  assign mem_fault_addr_valid_o = flag_q[`FSF_IDX_MEMVALID];
  assign bus_fault_address_o    = bus_addr_q;
  assign mem_fault_address_o    = mem_addr_q;

endmodule // fsf_status

`default_nettype wire

// ---- tb/fsf_status_monitor.sv ----
// Port assertions for the fault status flag block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fsf_status_chk (
  // Clock, reset, register port
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        priv_i,
  input wire logic [31:0] rdata_o,
  // Fault events
  input wire logic        precise_err_evt_i,
  input wire logic        imprecise_err_evt_i,
  input wire logic [31:0] data_fault_addr_i,
  input wire logic        mem_data_viol_evt_i,
  input wire logic        stacking_viol_evt_i,
  input wire logic [31:0] mem_fault_addr_i,
  input wire logic [7:0]  cur_prio_i,
  input wire logic [7:0]  bus_fault_prio_i,
  // Outputs
  input wire logic        imprecise_pending_o,
  input wire logic        imprecise_activate_o,
  input wire logic        fetch_fault_activate_o,
  input wire logic        stack_adjust_o,
  input wire logic [4:0]  flags_o,
  input wire logic [31:0] bus_fault_address_o,
  input wire logic [31:0] mem_fault_address_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_prec;
    precise_err_evt_i |=> flags_o[3] && bus_fault_address_o == $past(data_fault_addr_i);
  endproperty
  a_prec: assert property (p_prec) else $error("precise flag or address wrong");
  property p_imp;
    imprecise_err_evt_i |=> flags_o[4];
  endproperty
  a_imp: assert property (p_imp) else $error("imprecise flag not set");
  property p_pend;
    imprecise_pending_o && cur_prio_i < bus_fault_prio_i |=> !imprecise_activate_o;
  endproperty
  a_pend: assert property (p_pend) else $error("imprecise fault activated early");
  property p_fetch;
    $rose(flags_o[2]) |-> $past(fetch_fault_activate_o);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch flag set without issue");
  property p_noaddr;
    !precise_err_evt_i |=> $stable(bus_fault_address_o);
  endproperty
  a_noaddr: assert property (p_noaddr) else $error("bus fault address changed");
  property p_mv;
    mem_data_viol_evt_i && !stacking_viol_evt_i |=>
      flags_o[1] && mem_fault_address_o == $past(mem_fault_addr_i);
  endproperty
  a_mv: assert property (p_mv) else $error("memory address not captured");
  property p_stk;
    stacking_viol_evt_i |=> flags_o[0] && stack_adjust_o && $stable(mem_fault_address_o);
  endproperty
  a_stk: assert property (p_stk) else $error("stacking violation handling wrong");
  property p_w1c;
    wr_i && priv_i && addr_i == 8'h00 && wdata_i[9] && !precise_err_evt_i |=> !flags_o[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_hold;
    $fell(flags_o[3]) |-> $past(wr_i) && $past(priv_i) && $past(wdata_i[9]) && $past(addr_i) == 8'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("flag cleared without write");
  property p_rsvd;
    $past(rd_i) && $past(priv_i) && $past(addr_i) == 8'h00 |-> rdata_o[6:5] == 2'h0 && rdata_o[31:11] == 21'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read bits not zero");
  c_act: cover property (imprecise_activate_o);
  c_fetch: cover property (fetch_fault_activate_o);
  c_both: cover property (stacking_viol_evt_i && mem_data_viol_evt_i);
endmodule // fsf_status_chk
bind fsf_status fsf_status_chk u_fsf_status_chk (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .priv_i, .rdata_o, .precise_err_evt_i, .imprecise_err_evt_i, .data_fault_addr_i,
  .mem_data_viol_evt_i, .stacking_viol_evt_i, .mem_fault_addr_i, .cur_prio_i, .bus_fault_prio_i,
  .imprecise_pending_o, .imprecise_activate_o, .fetch_fault_activate_o, .stack_adjust_o,
  .flags_o, .bus_fault_address_o, .mem_fault_address_o);
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench for the fault status flag block.
// Assumes fsf_status and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i, srst_i, wr_i, rd_i, priv_i;
  logic [7:0]  addr_i, cur_prio_i, bus_fault_prio_i;
  logic [31:0] wdata_i, data_fault_addr_i, mem_fault_addr_i;
  logic [6:0]  ev;
  wire         precise_err_evt_i = ev[0];
  wire         imprecise_err_evt_i = ev[1];
  wire         prefetch_err_evt_i = ev[2];
  wire         mem_data_viol_evt_i = ev[3];
  wire         stacking_viol_evt_i = ev[4];
  wire         issue_i = ev[5];
  wire         fetch_flush_i = ev[6];
  wire [31:0]  rdata_o, bus_fault_address_o, mem_fault_address_o;
  wire [4:0]   flags_o;
  wire         imprecise_pending_o, imprecise_activate_o, fetch_fault_activate_o;
  wire         stack_adjust_o, mem_fault_addr_valid_o;
  int          n_errors, comparisons;
  fsf_status u_fsf_status (.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .priv_i, .rdata_o,
    .precise_err_evt_i, .imprecise_err_evt_i, .data_fault_addr_i, .prefetch_err_evt_i, .issue_i,
    .fetch_flush_i, .mem_data_viol_evt_i, .stacking_viol_evt_i, .mem_fault_addr_i, .cur_prio_i,
    .bus_fault_prio_i, .imprecise_pending_o, .imprecise_activate_o, .fetch_fault_activate_o,
    .stack_adjust_o, .flags_o, .mem_fault_addr_valid_o, .bus_fault_address_o, .mem_fault_address_o);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", rdata_o, exp);
  endtask
  task automatic pulse(input logic [6:0] m, input logic [31:0] a);
    @(posedge clk_i);
    ev <= m;
    data_fault_addr_i <= a;
    mem_fault_addr_i <= a;
    @(posedge clk_i);
    ev <= 7'h00;
    #1;
  endtask
  task automatic t_bus;
    rd(8'h0C, 32'h0);
    pulse(7'h01, 32'hA5A50004);
    rd(8'h04, 32'hA5A50004);
    @(posedge clk_i);
    cur_prio_i <= 8'h01;
    pulse(7'h02, 32'h0);
    repeat (3) @(posedge clk_i);
    #1 chk("pending", imprecise_pending_o, 32'h1);
    chk("activate", imprecise_activate_o, 32'h0);
    rd(8'h00, 32'h00000600);
    @(posedge clk_i);
    cur_prio_i <= 8'h04;
    @(posedge clk_i);
    #1 chk("activate", imprecise_activate_o, 32'h1);
    chk("pending", imprecise_pending_o, 32'h0);
    wr(8'h00, 32'h00000600);
    rd(8'h00, 32'h0);
  endtask
  task automatic t_fetch;
    pulse(7'h04, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk("fetch flag", flags_o[2], 32'h0);
    @(posedge clk_i);
    ev <= 7'h20;
    #1 chk("fetch act", fetch_fault_activate_o, 32'h1);
    @(posedge clk_i);
    ev <= 7'h00;
    #1 chk("fetch flag", flags_o[2], 32'h1);
    rd(8'h04, 32'hA5A50004);
    wr(8'h00, 32'h00000100);
    pulse(7'h04, 32'h0);
    pulse(7'h40, 32'h0);
    pulse(7'h20, 32'h0);
    rd(8'h00, 32'h0);
  endtask
  task automatic t_mem;
    pulse(7'h08, 32'h20000010);
    chk("addr valid", mem_fault_addr_valid_o, 32'h1);
    rd(8'h00, 32'h00000080);
    pulse(7'h18, 32'h20000020);
    chk("stack adj", stack_adjust_o, 32'h1);
    rd(8'h08, 32'h20000010);
    wr(8'h00, 32'h00000080);
    rd(8'h00, 32'h00000010);
  endtask
  task automatic t_w1c;
    pulse(7'h0B, 32'h0);
    chk("activate", imprecise_activate_o, 32'h1);
    wr(8'h00, 32'h00000060);
    @(posedge clk_i);
    priv_i <= 1'b0;
    wr(8'h00, 32'hFFFFFFFF);
    priv_i <= 1'b1;
    rd(8'h00, 32'h00000690);
    @(posedge clk_i);
    wdata_i <= 32'h00000200;
    wr_i <= 1'b1;
    ev <= 7'h01;
    @(posedge clk_i);
    wr_i <= 1'b0;
    ev <= 7'h00;
    #1 chk("set wins", flags_o[3], 32'h1);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0);
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {srst_i, priv_i} = 2'h3;
    {wr_i, rd_i, addr_i, wdata_i, ev} = '0;
    {data_fault_addr_i, mem_fault_addr_i} = '0;
    cur_prio_i = 8'h08;
    bus_fault_prio_i = 8'h04;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_bus;
    t_fetch;
    t_mem;
    t_w1c;
    give_verdict;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_errors++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
